// >>> rp_target.sv
// Regulator two-wire target port with register file and discharge control
// Overview of operation
// - Acknowledge own address after START, write direction.
// - Acknowledge implemented pointer, otherwise not-acknowledge.
// - Repeated START, read address, acknowledge, drive data.
// - Shift bytes out while host acknowledges.
// - On host not-acknowledge release line, stop sending.
// - Pointer advances per byte, except at 0x00.
// - Acknowledge holds data low over ninth clock.
// - Not-acknowledge leaves data high over ninth clock.
// - Both sides acknowledge; a target not-acknowledge means failure, a host one after the last byte ends the read.
// - Active discharge 50ms on shutdown when selected.
// - Passive discharge held during shutdown when selected.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rp_map.svh"
module rp_target #(
   parameter bit         VARIANT_B = 1'b1,
   parameter logic [7:0] CHIP_ID   = 8'hA5,  // Arbitrary value
   parameter int         DSC_CYC   = `RP_DSC_CYC
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   rp_link_if.dev          link,
   input  wire logic       regulator_en,
   input  wire logic [7:0] status_in,
   input  wire logic [7:0] event_in,
   output logic      [7:0] converter_config_a,
   output logic      [7:0] output_voltage_setting,
   output logic      [7:0] peak_current_setting,
   output logic      [7:0] converter_config_b,
   output logic      [7:0] interrupt_mask,
   output logic            active_discharge_on,
   output logic            passive_discharge_on
);
   localparam int DW = $clog2(DSC_CYC + 1);
   localparam logic [6:0] OWN_ADDR = VARIANT_B ? `RP_ADDR_B : `RP_ADDR_X;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus conditions
   logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      end else begin
         {scl_m_q, scl_s_q, scl_p_q} <= {link.scl, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {link.sda, sda_m_q, sda_s_q};
      end
   end
   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register helpers
   function automatic logic ptr_ok(input logic [7:0] p);
      ptr_ok = (p <= `RP_OFS_MASK) || (p == `RP_OFS_LMSK) || (p == `RP_OFS_LKEY);
   endfunction : ptr_ok
   function automatic logic [7:0] ptr_next(input logic [7:0] p);
      ptr_next = (p == `RP_OFS_ID) ? p : p + 8'h01;
   endfunction : ptr_next

   rp_pkg::rp_dev_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, ptr_q, int_q, lmsk_q, lkey_q, rd_byte;
   logic       rw_q, oe_q, wr_en, rd_load;

   always_comb begin
      unique case (ptr_q)
         `RP_OFS_ID:   rd_byte = CHIP_ID;
         `RP_OFS_CFGA: rd_byte = converter_config_a;
         `RP_OFS_VSET: rd_byte = output_voltage_setting;
         `RP_OFS_IPK:  rd_byte = peak_current_setting;
         `RP_OFS_CFGB: rd_byte = converter_config_b;
         `RP_OFS_STAT: rd_byte = status_in;
         `RP_OFS_INT:  rd_byte = int_q;
         `RP_OFS_MASK: rd_byte = interrupt_mask;
         `RP_OFS_LMSK: rd_byte = lmsk_q;
         `RP_OFS_LKEY: rd_byte = lkey_q;
         default:      rd_byte = 8'h00;
      endcase
   end
   assign wr_en   = scl_fall & (state_q == rp_pkg::D_WR) & (cnt_q == 4'h8);
   assign rd_load = scl_fall & (((state_q == rp_pkg::D_AACK) & rw_q) |
                                (state_q == rp_pkg::D_RACK));

   ////////////////////////////////////////////////////////////////////////////
   // Serial protocol engine
   always_ff @(posedge clk) begin
      if (sys_rst || stop_c) begin
         state_q <= rp_pkg::D_IDLE;
         cnt_q   <= 4'h0;
         oe_q    <= 1'b0;
      end else if (start_c) begin
         state_q <= rp_pkg::D_ADDR;
         cnt_q   <= 4'h0;
         oe_q    <= 1'b0;
      end else if (scl_rise) begin
         unique case (state_q)
            rp_pkg::D_ADDR, rp_pkg::D_PTR, rp_pkg::D_WR: begin
               sh_q  <= {sh_q[6:0], sda_s_q};
               cnt_q <= cnt_q + 4'h1;
            end
            rp_pkg::D_RD: cnt_q <= cnt_q + 4'h1;
            rp_pkg::D_RACK: if (sda_s_q) state_q <= rp_pkg::D_WAIT;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (state_q)
            rp_pkg::D_ADDR: if (cnt_q == 4'h8) begin
               if (sh_q[7:1] == OWN_ADDR) begin
                  state_q <= rp_pkg::D_AACK;
                  oe_q    <= 1'b1;
                  rw_q    <= sh_q[0];
               end else begin
                  state_q <= rp_pkg::D_IDLE;
               end
            end
            rp_pkg::D_AACK: begin
               cnt_q <= 4'h0;
               if (rw_q) begin
                  state_q <= rp_pkg::D_RD;
                  oe_q    <= ~rd_byte[7];
                  sh_q    <= {rd_byte[6:0], 1'b0};
               end else begin
                  state_q <= rp_pkg::D_PTR;
                  oe_q    <= 1'b0;
               end
            end
            rp_pkg::D_PTR: if (cnt_q == 4'h8) begin
               if (ptr_ok(sh_q)) begin
                  ptr_q   <= sh_q;
                  oe_q    <= 1'b1;
                  state_q <= rp_pkg::D_PACK;
               end else begin
                  oe_q    <= 1'b0;
                  state_q <= rp_pkg::D_WAIT;
               end
            end
            rp_pkg::D_PACK, rp_pkg::D_WACK: begin
               oe_q    <= 1'b0;
               cnt_q   <= 4'h0;
               state_q <= rp_pkg::D_WR;
            end
            rp_pkg::D_WR: if (cnt_q == 4'h8) begin
               oe_q    <= 1'b1;
               ptr_q   <= ptr_next(ptr_q);
               state_q <= rp_pkg::D_WACK;
            end
            rp_pkg::D_RD: begin
               if (cnt_q == 4'h8) begin
                  oe_q    <= 1'b0;
                  ptr_q   <= ptr_next(ptr_q);
                  state_q <= rp_pkg::D_RACK;
               end else begin
                  oe_q <= ~sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b0};
               end
            end
            rp_pkg::D_RACK: begin
               state_q <= rp_pkg::D_RD;
               cnt_q   <= 4'h0;
               oe_q    <= ~rd_byte[7];
               sh_q    <= {rd_byte[6:0], 1'b0};
            end
            default: ;
         endcase
      end
   end
   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         converter_config_a     <= `RP_RST_CFGA;
         output_voltage_setting <= VARIANT_B ? `RP_RST_VSET_B : `RP_RST_VSET_X;
         peak_current_setting   <= VARIANT_B ? `RP_RST_IPK_B : `RP_RST_IPK_X;
         converter_config_b     <= VARIANT_B ? `RP_RST_CFGB_B : `RP_RST_CFGB_X;
         interrupt_mask         <= `RP_RST_MASK;
         lmsk_q                 <= `RP_RST_LMSK;
         lkey_q                 <= `RP_RST_LKEY;
      end else if (wr_en) begin
         unique case (ptr_q)
            `RP_OFS_CFGA: converter_config_a     <= sh_q;
            `RP_OFS_VSET: output_voltage_setting <= sh_q;
            `RP_OFS_IPK:  peak_current_setting   <= sh_q;
            `RP_OFS_CFGB: converter_config_b     <= sh_q;
            `RP_OFS_MASK: interrupt_mask         <= sh_q;
            `RP_OFS_LMSK: lmsk_q                 <= sh_q;
            `RP_OFS_LKEY: lkey_q                 <= sh_q;
            default: ;
         endcase
      end
   end

   // Flags clear when read out; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_q <= `RP_RST_INT;
      end else begin
         int_q <= ((rd_load && ptr_q == `RP_OFS_INT) ? 8'h00 : int_q) | event_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output discharge on shutdown
   logic          en_q;
   logic [DW-1:0] dsc_cnt_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_q                 <= 1'b0;
         dsc_cnt_q            <= '0;
         active_discharge_on  <= 1'b0;
         passive_discharge_on <= 1'b0;
      end else begin
         en_q <= regulator_en;
         if (en_q && !regulator_en && converter_config_b[`RP_CFGB_ACT]) begin
            dsc_cnt_q <= DW'(DSC_CYC);
         end else if (regulator_en) begin
            dsc_cnt_q <= '0;
         end else if (dsc_cnt_q != '0) begin
            dsc_cnt_q <= dsc_cnt_q - 1'b1;
         end
         active_discharge_on  <= dsc_cnt_q != '0;
         passive_discharge_on <= !regulator_en && converter_config_b[`RP_CFGB_PSV];
      end
   end
endmodule : rp_target

// >>> rp_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RP_MAP_SVH
`define RP_MAP_SVH
`define RP_CLK_HZ      25000000
`define RP_SCL_HZ      400000
`define RP_QTR_CYC     (`RP_CLK_HZ / (4 * `RP_SCL_HZ))
`define RP_DSC_MS      50
`define RP_DSC_CYC     (`RP_CLK_HZ / 1000 * `RP_DSC_MS)
`define RP_ADDR_B      7'h28
`define RP_ADDR_X      7'h68
`define RP_OFS_ID      8'h00
`define RP_OFS_CFGA    8'h01
`define RP_OFS_VSET    8'h02
`define RP_OFS_IPK     8'h03
`define RP_OFS_CFGB    8'h04
`define RP_OFS_STAT    8'h05
`define RP_OFS_INT     8'h06
`define RP_OFS_MASK    8'h07
`define RP_OFS_LMSK    8'h50
`define RP_OFS_LKEY    8'h51
`define RP_RST_CFGA    8'h13
`define RP_RST_VSET_B  8'hCE
`define RP_RST_VSET_X  8'hF2
`define RP_RST_IPK_B   8'h84
`define RP_RST_IPK_X   8'h69
`define RP_RST_CFGB_B  8'h81
`define RP_RST_CFGB_X  8'hA1
`define RP_RST_INT     8'h00
`define RP_RST_MASK    8'h03
`define RP_RST_LMSK    8'h01
`define RP_RST_LKEY    8'hFF
`define RP_CFGB_ACT    7
`define RP_CFGB_PSV    0
`define RP_HOFS_CTRL   4'h0
`define RP_HOFS_STAT   4'h4
`define RP_HOFS_RXD    4'h8
`define RP_CTRL_GO     31
`endif

// >>> rp_pkg.sv
// Shared types of the regulator port link
package rp_pkg;
   typedef enum logic [3:0] {
      D_IDLE, D_ADDR, D_AACK, D_PTR, D_PACK, D_WR, D_WACK, D_RD, D_RACK, D_WAIT
   } rp_dev_state_t;
   typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} rp_host_state_t;
endpackage : rp_pkg

// >>> rp_link_if.sv
// Two-wire link between host controller and regulator port
`timescale 1ns/1ps
interface rp_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // Pulled-up open-drain wires
   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface : rp_link_if

// >>> rp_host.sv
// Host controller: burst read master with Avalon-MM command registers
`timescale 1ns/1ps
`include "rp_map.svh"
module rp_host #(
   parameter int QTR   = `RP_QTR_CYC,
   parameter int DEPTH = 2,
   parameter int W     = 8
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   rp_link_if.host          link
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer
   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wp_q, rp_q;
   logic [CW-1:0] fcnt_q;
   logic          in_valid, in_ready, out_valid, out_ready;
   logic [W-1:0]  rx_q;
   assign in_ready  = fcnt_q != CW'(DEPTH);
   assign out_valid = fcnt_q != '0;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wp_q   <= '0;
         rp_q   <= '0;
         fcnt_q <= '0;
      end else begin
         if (in_valid && in_ready) begin
            mem_q[wp_q] <= rx_q;
            wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         end
         if (out_valid && out_ready) begin
            rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         end
         fcnt_q <= fcnt_q + CW'(in_valid && in_ready) - CW'(out_valid && out_ready);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave
   rp_pkg::rp_host_state_t state_q;
   logic       ack_q, nack_q, go;
   logic [6:0] taddr_q;
   logic [7:0] ptr_q, left_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign go        = avs_write & ack_q & (avs_address == `RP_HOFS_CTRL) &
                      avs_writedata[`RP_CTRL_GO] & (state_q == rp_pkg::H_IDLE);
   assign out_ready = avs_read & ack_q & (avs_address == `RP_HOFS_RXD);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q        <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (avs_read && !ack_q) begin
            unique case (avs_address)
               `RP_HOFS_STAT: avs_readdata <= {29'h0, out_valid, nack_q,
                                               state_q != rp_pkg::H_IDLE};
               `RP_HOFS_RXD:  avs_readdata <= {{(32 - W){1'b0}}, mem_q[rp_q]};
               default:       avs_readdata <= 32'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit timing and data line synchroniser
   logic [7:0] div_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [1:0] seq_q;
   logic [7:0] tx_q;
   logic       tick, stall, adv, scl_oe_q, sda_oe_q, bad_q, sda_m_q, sda_s_q;
   assign tick  = (state_q != rp_pkg::H_IDLE) && (div_q == 8'(QTR - 1));
   assign stall = (state_q == rp_pkg::H_RX) && (ph_q == 2'h0) && (bit_q == 4'h0) &&
                  !in_ready;
   assign adv      = tick & ~stall;
   assign in_valid = adv && (state_q == rp_pkg::H_RX) && (ph_q == 2'h0) && (bit_q == 4'h8);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {sda_m_q, sda_s_q} <= 2'h3;
         div_q <= 8'h0;
         ph_q  <= 2'h0;
      end else begin
         {sda_m_q, sda_s_q} <= {link.sda, sda_m_q};
         div_q <= (go || tick) ? 8'h0 : div_q + 8'h01;
         ph_q  <= go ? 2'h0 : ph_q + 2'(adv);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= rp_pkg::H_IDLE;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         nack_q   <= 1'b0;
         seq_q    <= 2'h0;
      end else if (go) begin
         state_q <= rp_pkg::H_START;
         taddr_q <= avs_writedata[6:0];
         ptr_q   <= avs_writedata[15:8];
         left_q  <= (avs_writedata[23:16] == 8'h00) ? 8'h01 : avs_writedata[23:16];
         nack_q  <= 1'b0;
         seq_q   <= 2'h0;
      end else if (adv) begin
         unique case (state_q)
            rp_pkg::H_START: unique case (ph_q)
               2'h0: sda_oe_q <= 1'b0;
               2'h1: scl_oe_q <= 1'b0;
               2'h2: sda_oe_q <= 1'b1;
               2'h3: begin
                  scl_oe_q <= 1'b1;
                  state_q  <= rp_pkg::H_TX;
                  bit_q    <= 4'h0;
                  tx_q     <= {taddr_q, seq_q == 2'h2};
               end
            endcase
            rp_pkg::H_TX: unique case (ph_q)
               2'h0: sda_oe_q <= (bit_q != 4'h8) && !tx_q[7];
               2'h1: scl_oe_q <= 1'b0;
               2'h2: bad_q    <= (bit_q == 4'h8) && sda_s_q;
               2'h3: begin
                  scl_oe_q <= 1'b1;
                  tx_q     <= {tx_q[6:0], 1'b0};
                  bit_q    <= bit_q + 4'h1;
                  if (bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (bad_q) begin
                        nack_q  <= 1'b1;
                        state_q <= rp_pkg::H_STOP;
                     end else if (seq_q == 2'h0) begin
                        tx_q  <= ptr_q;
                        seq_q <= 2'h1;
                     end else if (seq_q == 2'h1) begin
                        seq_q   <= 2'h2;
                        state_q <= rp_pkg::H_START;
                     end else begin
                        seq_q   <= 2'h3;
                        state_q <= rp_pkg::H_RX;
                     end
                  end
               end
            endcase
            rp_pkg::H_RX: unique case (ph_q)
               2'h0: sda_oe_q <= (bit_q == 4'h8) && (left_q != 8'h01);
               2'h1: scl_oe_q <= 1'b0;
               2'h2: if (bit_q != 4'h8) rx_q <= {rx_q[W-2:0], sda_s_q};
               2'h3: begin
                  scl_oe_q <= 1'b1;
                  bit_q    <= bit_q + 4'h1;
                  if (bit_q == 4'h8) begin
                     bit_q  <= 4'h0;
                     left_q <= left_q - 8'h01;
                     if (left_q == 8'h01) state_q <= rp_pkg::H_STOP;
                  end
               end
            endcase
            rp_pkg::H_STOP: unique case (ph_q)
               2'h0: sda_oe_q <= 1'b1;
               2'h1: scl_oe_q <= 1'b0;
               2'h2: sda_oe_q <= 1'b0;
               2'h3: state_q  <= rp_pkg::H_IDLE;
            endcase
            default: ;
         endcase
      end
   end
   assign link.host_scl_o  = 1'b0;
   assign link.host_scl_oe = scl_oe_q;
   assign link.host_sda_o  = 1'b0;
   assign link.host_sda_oe = sda_oe_q;
endmodule : rp_host

// >>> rp_link_sva.sv
// Assertions on the two-wire link between host controller and regulator port
`timescale 1ns/1ps
module rp_link_sva #(
   parameter int QTR = 15
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   int   hi_cnt_q;
   int   lo_cnt_q;
   logic busy_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   ///////////////////////////////////////////////////////////////////////////
   // Clock phase lengths
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hi_cnt_q <= 0;
         lo_cnt_q <= 0;
      end else begin
         hi_cnt_q <= scl ? hi_cnt_q + 1 : 0;
         lo_cnt_q <= scl ? 0 : lo_cnt_q + 1;
      end
   end
   // Frame between START and STOP
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (scl && $past(scl) && $fell(sda)) begin
         busy_q <= 1'b1;
      end else if (scl && $past(scl) && $rose(sda)) begin
         busy_q <= 1'b0;
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   drive_zero_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("open-drain level not low");
   dev_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("target changed data while clock high");
   dev_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
      else $error("target drive too short");
   scl_high_a: assert property ($fell(scl) |-> hi_cnt_q >= 2 * QTR)
      else $error("clock high phase too short");
   scl_low_a: assert property ($rose(scl) |-> lo_cnt_q >= QTR)
      else $error("clock low phase too short");
   idle_quiet_a: assert property (!busy_q |-> !dev_sda_oe)
      else $error("target drives data outside a frame");
   dev_timing_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
      else $error("target changed data too close to clock fall");
   start_clear_a: assert property (scl && $past(scl) && $fell(sda) |-> !dev_sda_oe)
      else $error("target drives data at start");
   start_c: cover property (scl && $past(scl) && $fell(sda));
   stop_c: cover property (scl && $past(scl) && $rose(sda));
   ack_c: cover property ($rose(dev_sda_oe));
endmodule : rp_link_sva

// >>> tb.sv
// Self-checking bench joining host controller and regulator port
`timescale 1ns/1ps
`include "rp_map.svh"
module tb;
   localparam int         QTR  = 15;
   localparam int         DSC  = 20;
   localparam logic [7:0] ID_V = 8'h3C;  // Arbitrary value
   logic        clk           = 1'b0;
   logic        sys_rst       = 1'b1;
   logic [3:0]  avs_address   = 4'h0;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        regulator_en  = 1'b1;
   logic [7:0]  status_in     = 8'h5A;
   logic [7:0]  event_in      = 8'h00;
   logic [7:0]  cfg_a, vset, ipk, cfg_b, msk;
   logic        act_on, psv_on;
   logic [7:0]  none [$];
   int          error_cnt     = 0;
   int          checks        = 0;
   always #20 clk = ~clk;
   rp_link_if rp_link_if_i ();
   rp_host #(.QTR(QTR)) rp_host_i (
      .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(rp_link_if_i.host));
   rp_target #(.VARIANT_B(1'b1), .CHIP_ID(ID_V), .DSC_CYC(DSC)) rp_target_i (
      .clk(clk), .sys_rst(sys_rst), .link(rp_link_if_i.dev), .regulator_en(regulator_en),
      .status_in(status_in), .event_in(event_in), .converter_config_a(cfg_a),
      .output_voltage_setting(vset), .peak_current_setting(ipk), .converter_config_b(cfg_b),
      .interrupt_mask(msk), .active_discharge_on(act_on), .passive_discharge_on(psv_on));
   rp_link_sva #(.QTR(QTR)) rp_link_sva_i (
      .clk(clk), .sys_rst(sys_rst), .host_scl_o(rp_link_if_i.host_scl_o),
      .host_scl_oe(rp_link_if_i.host_scl_oe), .host_sda_o(rp_link_if_i.host_sda_o),
      .host_sda_oe(rp_link_if_i.host_sda_oe), .dev_sda_o(rp_link_if_i.dev_sda_o),
      .dev_sda_oe(rp_link_if_i.dev_sda_oe), .scl(rp_link_if_i.scl), .sda(rp_link_if_i.sda));
   ///////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // One Avalon cycle, held until waitrequest is low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   // Burst read; waits hold cycles first so the receive buffer fills
   task automatic burst(input logic [6:0] adr, input logic [7:0] ptr, input int hold,
                        input logic [7:0] exp [$], input logic nack);
      logic [31:0] d;
      logic [31:0] r;
      int          i;
      av(1'b1, `RP_HOFS_CTRL, {1'b1, 7'h00, 8'(exp.size() + 2 * nack), ptr, 1'b0, adr}, d);
      repeat (hold) @(posedge clk);
      i = 0;
      do begin
         av(1'b0, `RP_HOFS_STAT, 32'h0, d);
         if (d[2] === 1'b1) begin
            av(1'b0, `RP_HOFS_RXD, 32'h0, r);
            check("rx byte", r[7:0], (i < exp.size()) ? exp[i] : 8'h00);
            i++;
         end
      end while (d[0] !== 1'b0 || d[2] !== 1'b0);
      check("byte count", i, exp.size());
      check("nack flag", d[1], nack);
   endtask : burst
   task automatic t_regs;
      logic [31:0] d;
      av(1'b0, 4'hC, 32'h0, d);
      check("unmapped read", d, 32'h0);
      check("config ports", {cfg_a, vset, ipk, cfg_b, msk}, 40'h13CE848103);
      burst(`RP_ADDR_B, 8'h01, 3000,
            '{8'h13, 8'hCE, 8'h84, 8'h81, 8'h5A, 8'h00, 8'h03}, 1'b0);
      burst(`RP_ADDR_B, 8'h00, 0, '{ID_V, ID_V, ID_V}, 1'b0);
      burst(`RP_ADDR_B, 8'h50, 0, '{8'h01, 8'hFF}, 1'b0);
   endtask : t_regs
   task automatic t_int;
      @(posedge clk);
      event_in <= 8'h04;
      @(posedge clk);
      event_in <= 8'h00;
      burst(`RP_ADDR_B, 8'h06, 0, '{8'h04, 8'h03}, 1'b0);
      burst(`RP_ADDR_B, 8'h06, 0, '{8'h00}, 1'b0);
   endtask : t_int
   task automatic t_refuse;
      burst(`RP_ADDR_B, 8'h08, 0, none, 1'b1);
      burst(`RP_ADDR_B, 8'h4F, 0, none, 1'b1);
      burst(`RP_ADDR_B, 8'hFF, 0, none, 1'b1);
      burst(`RP_ADDR_X, 8'h01, 0, none, 1'b1);
   endtask : t_refuse
   task automatic t_dsc;
      int c;
      @(posedge clk);
      regulator_en <= 1'b0;
      c = 0;
      repeat (DSC + 10) begin
         @(negedge clk);
         c += (act_on === 1'b1);
      end
      check("active discharge cycles", c, DSC);
      check("passive discharge", psv_on, 1'b1);
      @(posedge clk);
      regulator_en <= 1'b1;
      repeat (3) @(negedge clk);
      check("passive discharge off", psv_on, 1'b0);
   endtask : t_dsc
   task automatic results;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   ///////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_regs();
      t_int();
      t_refuse();
      t_dsc();
      results();
   end
endmodule : tb
